// >>> bms_pkg.sv
package bms_pkg;

	// ----------------------------------------------------------------
	// I/O space map
	// ----------------------------------------------------------------
	localparam logic [15:0] PMS_ADDR        = 16'hffe4; // Program-memory status register
	localparam logic [15:0] BOOT_SEL_ADDR   = 16'h0000; // Boot selection word
	localparam logic [15:0] ROM_START_ADDR  = 16'h0000; // On-chip ROM start, branches to boot code

	// ----------------------------------------------------------------
	// Status register layout
	// ----------------------------------------------------------------
	localparam int          BIT_RD_SEL      = 15;       // Read strobe select
	localparam int          BIT_WIDTH_LVL   = 3;        // Captured width strap, read only
	localparam int          BIT_DATA_MAP    = 2;        // SRAM in data space
	localparam int          BIT_PROG_MAP    = 1;        // SRAM in program space
	localparam int          BIT_PROC_MODE   = 0;        // Processor mode
	localparam logic        RD_SEL_RST      = 1'b0;     // Enhanced read strobe at reset
	localparam logic [1:0]  SRAM_MAP_RST    = 2'b11;    // Data and program mapped at reset
	localparam logic [1:0]  SRAM_MAP_BOOT   = 2'b11;    // Boot code maps both
	localparam logic        BLOCK0_BOOT     = 1'b1;     // Boot code maps block zero to program
	localparam logic [2:0]  WAIT_STATES_RST = 3'h7;     // Seven wait states from reset

	// ----------------------------------------------------------------
	// SRAM windows
	// ----------------------------------------------------------------
	localparam logic [15:0] SRAM_PROG_BASE  = 16'h8000;
	localparam logic [15:0] SRAM_DATA_BASE  = 16'h0800;

	// ----------------------------------------------------------------
	// Boot modes
	// ----------------------------------------------------------------
	localparam logic [3:0]  MODE_NONE       = 4'h0;     // External execution, no boot
	localparam logic [3:0]  MODE_LEGACY8    = 4'h1;
	localparam logic [3:0]  MODE_SSP8       = 4'h2;
	localparam logic [3:0]  MODE_SSP16      = 4'h3;
	localparam logic [3:0]  MODE_PAR8       = 4'h4;
	localparam logic [3:0]  MODE_PAR16      = 4'h5;
	localparam logic [3:0]  MODE_UART8      = 4'h6;
	localparam logic [3:0]  MODE_EPROM8     = 4'h7;
	localparam logic [3:0]  MODE_EPROM16    = 4'h8;
	localparam logic [3:0]  MODE_WARM       = 4'h9;

	// Selection word: low two bits, then bits 4..2 when low bits are zero
	localparam logic [1:0]  SEL_LO_SERIAL   = 2'b00;
	localparam logic [1:0]  SEL_LO_EPROM8   = 2'b01;
	localparam logic [1:0]  SEL_LO_EPROM16  = 2'b10;
	localparam logic [1:0]  SEL_LO_WARM     = 2'b11;
	localparam logic [2:0]  SEL_SSP8        = 3'b000;
	localparam logic [2:0]  SEL_SSP16       = 3'b001;
	localparam logic [2:0]  SEL_PAR8        = 3'b010;
	localparam logic [2:0]  SEL_PAR16       = 3'b011;
	localparam logic [2:0]  SEL_UART8       = 3'b100;

	// ----------------------------------------------------------------
	// Interrupt vectoring
	// ----------------------------------------------------------------
	localparam logic [15:0] ROM_VEC_BASE    = 16'h0000;
	localparam logic [15:0] VEC_INT1        = 16'h8000;
	localparam logic [15:0] VEC_INT23       = 16'h8002;
	localparam logic [15:0] VEC_TIMER       = 16'h8004;
	localparam logic [15:0] VEC_SSP_RX      = 16'h801a;
	localparam logic [15:0] VEC_SSP_TX      = 16'h8032;
	localparam logic [15:0] VEC_UART        = 16'h804e;
	localparam logic [15:0] VEC_TRAP        = 16'h8050;
	localparam logic [15:0] VEC_NMI         = 16'h8052;
	localparam logic [15:0] VEC_SWI_LO      = 16'h8054;     // Software interrupts 8..16
	localparam logic [15:0] VEC_SWI_HI      = 16'h8066;     // Software interrupts 20..31
	localparam logic [15:0] VEC_RESERVED    = 16'h807e;
	localparam logic [4:0]  INUM_INT1       = 5'h01;
	localparam logic [4:0]  INUM_INT2       = 5'h02;
	localparam logic [4:0]  INUM_INT3       = 5'h03;
	localparam logic [4:0]  INUM_TIMER      = 5'h04;
	localparam logic [4:0]  INUM_SSP_RX     = 5'h05;
	localparam logic [4:0]  INUM_SSP_TX     = 5'h06;
	localparam logic [4:0]  INUM_UART       = 5'h07;
	localparam logic [4:0]  INUM_SWI_LO     = 5'h08;
	localparam logic [4:0]  INUM_SWI_LO_END = 5'h10;
	localparam logic [4:0]  INUM_TRAP       = 5'h11;
	localparam logic [4:0]  INUM_NMI        = 5'h12;
	localparam logic [4:0]  INUM_SWI_HI     = 5'h14;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS   = 10;
	localparam int          SEL_STROBE_NS   = 50;       // Least low time of the I/O strobe
	localparam int          SEL_STROBE_CYC  = (SEL_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          SYNC_DEPTH      = 2;        // Settle cycles of the pin synchronisers

endpackage

// >>> bms_sync2.sv
// ----------------------------------------------------------------
// Two-stage synchroniser for pins
// ----------------------------------------------------------------
module bms_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] syncOut
);

	// Both stages in one state word; only stage two is read outside
	typedef struct packed {
		logic [WIDTH-1:0] meta;     // First stage, read by stage two only
		logic [WIDTH-1:0] stable;   // Second stage
	} bms_sync_s;

	bms_sync_s cur_ff;
	bms_sync_s nxt_ff;

	// Next stage values
	always_comb
	begin
		nxt_ff        = cur_ff;
		nxt_ff.meta   = pinIn;
		nxt_ff.stable = cur_ff.meta;
	end

	// Registers with synchronous reset to constants
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur_ff <= '0;
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	assign syncOut = cur_ff.stable;

endmodule

// >>> bms_vector_map.sv
// ----------------------------------------------------------------
// Second-level vector lookup in program SRAM
// ----------------------------------------------------------------
module bms_vector_map (
	input  wire logic [4:0]  intNum,
	output logic      [15:0] sramVec,
	output logic             hasSram
);

	// Hard-coded entries; a two-word branch per entry
	always_comb
	begin
		sramVec = bms_pkg::VEC_RESERVED;
		hasSram = 1'b1;
		if (intNum >= bms_pkg::INUM_SWI_HI)
		begin
			// Upper software block, two-word spacing
			sramVec = bms_pkg::VEC_SWI_HI + {10'h0, 5'(intNum - bms_pkg::INUM_SWI_HI), 1'b0};
		end
		else if (intNum >= bms_pkg::INUM_SWI_LO && intNum <= bms_pkg::INUM_SWI_LO_END)
		begin
			// Lower software block
			sramVec = bms_pkg::VEC_SWI_LO + {10'h0, 5'(intNum - bms_pkg::INUM_SWI_LO), 1'b0};
		end
		else
		begin
			case (intNum)
				bms_pkg::INUM_INT1:   sramVec = bms_pkg::VEC_INT1;
				bms_pkg::INUM_INT2:   sramVec = bms_pkg::VEC_INT23;
				bms_pkg::INUM_INT3:   sramVec = bms_pkg::VEC_INT23;
				bms_pkg::INUM_TIMER:  sramVec = bms_pkg::VEC_TIMER;
				bms_pkg::INUM_SSP_RX: sramVec = bms_pkg::VEC_SSP_RX;
				bms_pkg::INUM_SSP_TX: sramVec = bms_pkg::VEC_SSP_TX;
				bms_pkg::INUM_UART:   sramVec = bms_pkg::VEC_UART;
				bms_pkg::INUM_TRAP:   sramVec = bms_pkg::VEC_TRAP;
				bms_pkg::INUM_NMI:    sramVec = bms_pkg::VEC_NMI;
				// Reset and the unused number have no SRAM entry
				default:              hasSram = 1'b0;
			endcase
		end
	end

endmodule

// >>> bms_boot_mode_select.sv
// Behaviour
// - Processor mode low: start ROM at 0000h
// - Width strap latched into read-only bit 3
// - Width high reads selection word, else legacy
// - Bit 15 resets 0, selects read strobe
// - Bits 14 to 4 read zero
// - SRAM map bits reset 11, decode windows
// - Bit 0 latches mode strap, software writable
// - Strap pair selects mode 0, 1 or 2-9
// - Boot maps block zero, both SRAM bits
// - Reset masks interrupts, seven wait states
// - Strobe low at 0000h, upper byte ignored
// - Selection codes for serial, parallel, UART
// - Low bits pick EPROM or warm boot
// - Interrupt goes ROM vector, then SRAM table in microcomputer mode
// - Interrupt and software entries, two-word spacing
// - Timer, serial, UART, trap, NMI entries
module bms_boot_mode_select #(
	parameter logic [15:0] SRAM_WORDS = 16'h1000 // Size of the single-access SRAM block
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic        procModeStrap,
	input  wire logic        bootWidthStrap,
	input  wire logic [15:0] ioAddr,
	input  wire logic [15:0] ioWrData,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	output logic      [15:0] ioRdData,
	output logic             ioRdAck,
	output logic      [15:0] extIoAddr,
	output logic             io_strobe_n,
	input  wire logic [15:0] extIoData,
	output logic      [15:0] execStartAddr,
	output logic             execStartValid,
	output logic      [3:0]  bootMode,
	output logic             bootModeValid,
	output logic      [5:0]  eepromSourceField,
	output logic      [5:0]  warmEntryField,
	output logic             bootSelError,
	input  wire logic        bootDone,
	output logic             readStrobeSelect,
	output logic             sramDataMap,
	output logic             sramProgMap,
	output logic             blockZeroMap,
	output logic             globalIntMask,
	input  wire logic        intMaskClear,
	output logic      [2:0]  waitStates,
	output logic             fullSpaceEnable,
	input  wire logic [15:0] memAddr,
	input  wire logic        memIsProg,
	output logic             sramSelect,
	input  wire logic        intReq,
	input  wire logic [4:0]  intNum,
	output logic      [15:0] vecFetchAddr,
	output logic             vecFetchValid
);

	// ----------------------------------------------------------------
	// Types and state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		BST_SETTLE,     // Let the strap synchronisers fill
		BST_LATCH,      // Capture the straps
		BST_ROM_SETUP,  // ROM boot code sets up memory
		BST_SEL_FETCH,  // Strobe low on the selection word
		BST_DECODE,     // Decode the sampled word
		BST_HANDOFF,    // Mode loader runs
		BST_RUN         // User code runs
	} bms_boot_e;

	typedef enum logic [1:0] {
		IV_IDLE,        // No vectoring in progress
		IV_ROM,         // First-level ROM vector issued
		IV_SRAM         // Second-level SRAM branch issued
	} bms_vec_e;

	typedef struct packed {
		bms_boot_e   boot;        // Boot sequencer
		bms_vec_e    vec;         // Vectoring sequencer
		logic [3:0]  cnt;         // Settle and strobe counter
		logic        rdSel;       // Status bit 15
		logic        widthLvl;    // Status bit 3
		logic        dataMap;     // Status bit 2
		logic        progMap;     // Status bit 1
		logic        procMode;    // Status bit 0
		logic        block0;      // Block zero in program space
		logic        intMask;     // Global interrupt mask
		logic [15:0] rdData;      // Register read answer
		logic        rdAck;       // Read answer marker
		logic [15:0] extAddr;     // I/O address driven out
		logic        strobeN;     // I/O strobe, active low
		logic [15:0] startAddr;   // Execution start address
		logic        startValid;  // Start address valid
		logic [3:0]  mode;        // Selected boot mode
		logic        modeValid;   // Mode valid for loaders
		logic [5:0]  srcField;    // EPROM source field
		logic [5:0]  entryField;  // Warm-boot entry field
		logic        selErr;      // Unknown selection code
		logic        sramSel;     // Access falls in SRAM
		logic [15:0] vecAddr;     // Vector fetch address
		logic        vecValid;    // Vector fetch strobe
		logic [2:0]  waits;       // Wait states, fixed after reset
		logic        spaceEn;     // Full program and data spaces enabled
	} bms_state_s;

	bms_state_s cur_ff;
	bms_state_s nxt_ff;

	logic [1:0]  strapSync;      // Synchronised straps, bit 1 mode, bit 0 width
	logic [15:0] selWordSync;    // Synchronised selection word
	logic [15:0] sramVec;        // Second-level vector for intNum
	logic        hasSram;        // intNum has a second-level entry
	logic [15:0] statusWord;     // Assembled status register
	logic        regHit;         // Bus addresses the status register

	// ----------------------------------------------------------------
	// Pin synchronisers and vector lookup
	// ----------------------------------------------------------------
	bms_sync2 #(.WIDTH(2)) u_strap_sync (.clk(clk), .sys_rst(sys_rst),
		.pinIn({procModeStrap, bootWidthStrap}), .syncOut(strapSync));

	// External word arrives from a switch outside the clock domain
	bms_sync2 #(.WIDTH(16)) u_sel_sync (.clk(clk), .sys_rst(sys_rst), .pinIn(extIoData), .syncOut(selWordSync));

	bms_vector_map u_vec_map (.intNum(intNum), .sramVec(sramVec), .hasSram(hasSram));

	// ----------------------------------------------------------------
	// Status word assembly
	// ----------------------------------------------------------------
	// Unused bits stay zero, so reads return zero there
	always_comb
	begin
		statusWord                        = '0;
		statusWord[bms_pkg::BIT_RD_SEL]    = cur_ff.rdSel;
		statusWord[bms_pkg::BIT_WIDTH_LVL] = cur_ff.widthLvl;
		statusWord[bms_pkg::BIT_DATA_MAP]  = cur_ff.dataMap;
		statusWord[bms_pkg::BIT_PROG_MAP]  = cur_ff.progMap;
		statusWord[bms_pkg::BIT_PROC_MODE] = cur_ff.procMode;
	end

	assign regHit = (ioAddr == bms_pkg::PMS_ADDR);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_ff          = cur_ff;
		nxt_ff.rdAck    = 1'b0;
		nxt_ff.vecValid = 1'b0;

		// Register read: one-cycle answer, other addresses read zero
		if (ioRd)
		begin
			nxt_ff.rdAck  = 1'b1;
			nxt_ff.rdData = regHit ? statusWord : '0;
		end

		// Register write: only bits 15, 2, 1, 0 take the data
		if (ioWr && regHit)
		begin
			nxt_ff.rdSel    = ioWrData[bms_pkg::BIT_RD_SEL];
			nxt_ff.dataMap  = ioWrData[bms_pkg::BIT_DATA_MAP];
			nxt_ff.progMap  = ioWrData[bms_pkg::BIT_PROG_MAP];
			nxt_ff.procMode = ioWrData[bms_pkg::BIT_PROC_MODE];
			// Bit 3 and reserved bits are left untouched
		end

		// User code enabling interrupts clears the mask
		if (intMaskClear && cur_ff.boot == BST_RUN)
			nxt_ff.intMask = 1'b0;

		// Boot sequencer
		case (cur_ff.boot)
			BST_SETTLE:
			begin
				// Straps become valid once both stages have filled
				nxt_ff.cnt = cur_ff.cnt + 4'h1;
				if (cur_ff.cnt == 4'(bms_pkg::SYNC_DEPTH - 1))
					nxt_ff.boot = BST_LATCH;
			end
			BST_LATCH:
			begin
				nxt_ff.procMode = strapSync[1];
				nxt_ff.widthLvl = strapSync[0];
				nxt_ff.cnt      = '0;
				// Execution starts at 0000h, in on-chip ROM or outside
				nxt_ff.startAddr  = bms_pkg::ROM_START_ADDR;
				nxt_ff.startValid = 1'b1;
				nxt_ff.boot       = BST_ROM_SETUP;
				if (strapSync[1])
				begin
					// Microprocessor mode: width strap has no effect
					nxt_ff.mode = bms_pkg::MODE_NONE;
					nxt_ff.boot = BST_RUN;
				end
			end
			BST_ROM_SETUP:
			begin
				// Boot code maps block zero and SRAM into program space
				nxt_ff.block0  = bms_pkg::BLOCK0_BOOT;
				nxt_ff.dataMap = bms_pkg::SRAM_MAP_BOOT[1];
				nxt_ff.progMap = bms_pkg::SRAM_MAP_BOOT[0];
				if (cur_ff.widthLvl)
				begin
					// Enhanced boot: fetch the selection word
					nxt_ff.extAddr = bms_pkg::BOOT_SEL_ADDR;
					nxt_ff.strobeN = 1'b0;
					nxt_ff.boot    = BST_SEL_FETCH;
				end
				else
				begin
					// Legacy 8-bit EPROM boot
					nxt_ff.mode      = bms_pkg::MODE_LEGACY8;
					nxt_ff.modeValid = 1'b1;
					nxt_ff.boot      = BST_HANDOFF;
				end
			end
			BST_SEL_FETCH:
			begin
				// Strobe stays low long enough plus the synchroniser delay
				nxt_ff.cnt = cur_ff.cnt + 4'h1;
				if (cur_ff.cnt == 4'(bms_pkg::SEL_STROBE_CYC + bms_pkg::SYNC_DEPTH - 1))
				begin
					nxt_ff.strobeN = 1'b1;
					nxt_ff.cnt     = '0;
					nxt_ff.boot    = BST_DECODE;
				end
			end
			BST_DECODE:
			begin
				// Only the low byte matters; the upper byte is dropped
				nxt_ff.srcField   = selWordSync[7:2];
				nxt_ff.entryField = selWordSync[7:2];
				nxt_ff.selErr     = 1'b0;
				case (selWordSync[1:0])
					bms_pkg::SEL_LO_EPROM8:  nxt_ff.mode = bms_pkg::MODE_EPROM8;
					bms_pkg::SEL_LO_EPROM16: nxt_ff.mode = bms_pkg::MODE_EPROM16;
					bms_pkg::SEL_LO_WARM:    nxt_ff.mode = bms_pkg::MODE_WARM;
					default:
					begin
						// Serial, parallel or UART, picked by bits 4..2
						case (selWordSync[4:2])
							bms_pkg::SEL_SSP8:  nxt_ff.mode = bms_pkg::MODE_SSP8;
							bms_pkg::SEL_SSP16: nxt_ff.mode = bms_pkg::MODE_SSP16;
							bms_pkg::SEL_PAR8:  nxt_ff.mode = bms_pkg::MODE_PAR8;
							bms_pkg::SEL_PAR16: nxt_ff.mode = bms_pkg::MODE_PAR16;
							bms_pkg::SEL_UART8: nxt_ff.mode = bms_pkg::MODE_UART8;
							default:
							begin
								// Unlisted code: no loader is started
								nxt_ff.mode   = bms_pkg::MODE_NONE;
								nxt_ff.selErr = 1'b1;
							end
						endcase
					end
				endcase
				nxt_ff.modeValid = 1'b1;
				nxt_ff.boot      = BST_HANDOFF;
			end
			BST_HANDOFF:
			begin
				// The loader reports completion; interrupts stay masked
				if (bootDone)
				begin
					nxt_ff.modeValid = 1'b0;
					nxt_ff.boot      = BST_RUN;
				end
			end
			BST_RUN:  nxt_ff.boot = BST_RUN;
			default:  nxt_ff.boot = BST_SETTLE;
		endcase

		// SRAM window decode on the current map bits
		if (memIsProg)
			nxt_ff.sramSel = cur_ff.progMap && memAddr >= bms_pkg::SRAM_PROG_BASE
				&& memAddr < bms_pkg::SRAM_PROG_BASE + SRAM_WORDS;
		else
			nxt_ff.sramSel = cur_ff.dataMap && memAddr >= bms_pkg::SRAM_DATA_BASE
				&& memAddr < bms_pkg::SRAM_DATA_BASE + SRAM_WORDS;

		// Interrupt vectoring: ROM vector first, then the SRAM entry in microcomputer mode
		case (cur_ff.vec)
			IV_IDLE:
			begin
				if (intReq && cur_ff.boot == BST_RUN)
				begin
					nxt_ff.vecAddr  = bms_pkg::ROM_VEC_BASE + {10'h0, intNum, 1'b0};
					nxt_ff.vecValid = 1'b1;
					// ROM's second hop exists only in microcomputer mode
					nxt_ff.vec = (!cur_ff.procMode && hasSram) ? IV_ROM : IV_IDLE;
				end
			end
			IV_ROM:
			begin
				// intNum must be held while the two hops are issued
				nxt_ff.vecAddr  = sramVec;
				nxt_ff.vecValid = 1'b1;
				nxt_ff.vec      = IV_SRAM;
			end
			IV_SRAM:  nxt_ff.vec = IV_IDLE;
			default:  nxt_ff.vec = IV_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Reset loads constants; straps are caught after release
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			cur_ff          <= '0;
			cur_ff.boot     <= BST_SETTLE;
			cur_ff.vec      <= IV_IDLE;
			cur_ff.rdSel    <= bms_pkg::RD_SEL_RST;
			cur_ff.dataMap  <= bms_pkg::SRAM_MAP_RST[1];
			cur_ff.progMap  <= bms_pkg::SRAM_MAP_RST[0];
			cur_ff.intMask  <= 1'b1;
			cur_ff.strobeN  <= 1'b1;
			cur_ff.waits    <= bms_pkg::WAIT_STATES_RST;
			cur_ff.spaceEn  <= 1'b1;
		end
		else
		begin
			cur_ff <= nxt_ff;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from the state register
	// ----------------------------------------------------------------
	assign ioRdData          = cur_ff.rdData;
	assign ioRdAck           = cur_ff.rdAck;
	assign extIoAddr         = cur_ff.extAddr;
	assign io_strobe_n       = cur_ff.strobeN;
	assign execStartAddr     = cur_ff.startAddr;
	assign execStartValid    = cur_ff.startValid;
	assign bootMode          = cur_ff.mode;
	assign bootModeValid     = cur_ff.modeValid;
	assign eepromSourceField = cur_ff.srcField;
	assign warmEntryField    = cur_ff.entryField;
	assign bootSelError      = cur_ff.selErr;
	assign readStrobeSelect  = cur_ff.rdSel;
	assign sramDataMap       = cur_ff.dataMap;
	assign sramProgMap       = cur_ff.progMap;
	assign blockZeroMap      = cur_ff.block0;
	assign globalIntMask     = cur_ff.intMask;
	assign sramSelect        = cur_ff.sramSel;
	assign vecFetchAddr      = cur_ff.vecAddr;
	assign vecFetchValid     = cur_ff.vecValid;
	// Wait states and space enables keep their reset setting
	assign waitStates        = cur_ff.waits;
	assign fullSpaceEnable   = cur_ff.spaceEn;

endmodule

// >>> bms_boot_mode_select_monitor.sv
module bms_boot_mode_select_monitor (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        ioRd,
	input wire logic        ioWr,
	input wire logic [15:0] ioAddr,
	input wire logic        ioRdAck,
	input wire logic [15:0] ioRdData,
	input wire logic        io_strobe_n,
	input wire logic [15:0] extIoAddr,
	input wire logic        execStartValid,
	input wire logic [15:0] execStartAddr,
	input wire logic [2:0]  waitStates,
	input wire logic        fullSpaceEnable,
	input wire logic        globalIntMask,
	input wire logic        intMaskClear,
	input wire logic        vecFetchValid,
	input wire logic [15:0] vecFetchAddr,
	input wire logic [4:0]  intNum,
	input wire logic        bootModeValid,
	input wire logic [3:0]  bootMode,
	input wire logic        sramDataMap,
	input wire logic        sramProgMap,
	input wire logic        readStrobeSelect
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Selection fetch strobe: seven low cycles, then released
	sequence sStrobeLow;
		!io_strobe_n [*7] ##1 io_strobe_n;
	endsequence
	a_rd_ack: assert property (ioRdAck == $past(ioRd)) else $error("read ack timing wrong");
	a_rsvd_zero: assert property (ioRdAck |-> ioRdData[14:4] == 11'h000) else $error("reserved bits nonzero");
	a_map_mirror: assert property (ioRdAck && $past(ioAddr) == 16'hffe4 && !$past(ioWr) |->
		ioRdData[2:1] == {sramDataMap, sramProgMap} && ioRdData[15] == readStrobeSelect) else $error("map bits differ");
	a_strobe_addr: assert property (!io_strobe_n |-> extIoAddr == 16'h0000) else $error("fetch address wrong");
	a_strobe_len: assert property ($fell(io_strobe_n) |-> sStrobeLow) else $error("strobe length wrong");
	a_start_addr: assert property (execStartValid |-> execStartAddr == 16'h0000) else $error("start address wrong");
	a_wait_cfg: assert property (waitStates == 3'h7 && fullSpaceEnable) else $error("space setup wrong");
	a_mask_clr: assert property ($fell(globalIntMask) |-> $past(intMaskClear)) else $error("mask cleared alone");
	a_vec_rom: assert property ($rose(vecFetchValid) |->
		vecFetchAddr == {10'h000, $past(intNum), 1'b0}) else $error("rom vector wrong");
	a_mode_range: assert property (bootModeValid |-> bootMode inside {[4'h1:4'h9]}) else $error("mode out of range");
endmodule

bind bms_boot_mode_select bms_boot_mode_select_monitor bms_boot_mode_select_monitor_inst (.clk, .sys_rst, .ioRd,
	.ioWr, .ioAddr, .ioRdAck, .ioRdData, .io_strobe_n, .extIoAddr, .execStartValid, .execStartAddr, .waitStates,
	.fullSpaceEnable, .globalIntMask, .intMaskClear, .vecFetchValid, .vecFetchAddr, .intNum, .bootModeValid,
	.bootMode, .sramDataMap, .sramProgMap, .readStrobeSelect);

// >>> bms_sel_switch.sv
// Selection switch; it loads nothing, so never targets ROM or the vector table
module bms_sel_switch (
	input wire logic        io_strobe_n,
	input wire logic [15:0] extIoAddr,
	input wire logic [15:0] selWord,
	output logic     [15:0] extIoData
);
	timeunit 1ns;
	timeprecision 1ps;
	// Unselected bus shows the inverse, so a late sample cannot pass by luck
	assign extIoData = (!io_strobe_n && extIoAddr == 16'h0000) ? selWord : ~selWord;
endmodule

// >>> bms_boot_mode_select_tb.sv
module bms_boot_mode_select_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, sys_rst = 1'b1, procModeStrap = 1'b0, bootWidthStrap = 1'b0, ioWr = 1'b0, ioRd = 1'b0;
	logic bootDone = 1'b0, intMaskClear = 1'b0, memIsProg = 1'b0, intReq = 1'b0;
	logic [15:0] ioAddr = 16'h0000, ioWrData = 16'h0000, memAddr = 16'h0000, selWord = 16'h0000, r;
	logic [4:0] intNum = 5'h00;
	logic [15:0] ioRdData, extIoAddr, extIoData, execStartAddr, vecFetchAddr;
	logic [3:0] bootMode;
	logic [5:0] eepromSourceField, warmEntryField;
	logic [2:0] waitStates;
	logic ioRdAck, io_strobe_n, execStartValid, bootModeValid, bootSelError, readStrobeSelect, sramDataMap;
	logic sramProgMap, blockZeroMap, globalIntMask, fullSpaceEnable, sramSelect, vecFetchValid;
	logic [7:0] lo[$] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h01, 8'h02, 8'h03};
	int fails = 0, samples_checked = 0;
	always #5 clk = ~clk;
	bms_boot_mode_select bms_boot_mode_select_inst (.clk, .sys_rst, .procModeStrap, .bootWidthStrap, .ioAddr,
		.ioWrData, .ioWr, .ioRd, .ioRdData, .ioRdAck, .extIoAddr, .io_strobe_n, .extIoData, .execStartAddr,
		.execStartValid, .bootMode, .bootModeValid, .eepromSourceField, .warmEntryField, .bootSelError, .bootDone,
		.readStrobeSelect, .sramDataMap, .sramProgMap, .blockZeroMap, .globalIntMask, .intMaskClear, .waitStates,
		.fullSpaceEnable, .memAddr, .memIsProg, .sramSelect, .intReq, .intNum, .vecFetchAddr, .vecFetchValid);
	bms_sel_switch bms_sel_switch_inst (.io_strobe_n, .extIoAddr, .selWord, .extIoData);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Reference mode choice from straps and the low selection bits
	function automatic logic [3:0] expMode(input logic pm, input logic w, input logic [15:0] s);
		if (pm)
			return 4'h0;
		if (!w)
			return 4'h1;
		if (s[1:0] != 2'b00)
			return 4'h6 + 4'(s[1:0]);
		return 4'h2 + 4'(s[4:2]);
	endfunction
	function automatic logic [15:0] expVec(input int n);
		case (n)
			1: return 16'h8000;
			2, 3: return 16'h8002;
			4: return 16'h8004;
			5: return 16'h801a;
			6: return 16'h8032;
			7: return 16'h804e;
			17: return 16'h8050;
			18: return 16'h8052;
			default: return 16'(n < 17 ? 32'h8054 + 2 * (n - 8) : 32'h8066 + 2 * (n - 20));
		endcase
	endfunction
	// Full reset, then the fixed boot walk ends by cycle 12
	task automatic boot(input logic pm, input logic w, input logic [15:0] s);
		@(posedge clk);
		sys_rst <= 1'b1;
		procModeStrap <= pm;
		bootWidthStrap <= w;
		selWord <= s;
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		chk(execStartValid, 1'b1);
		chk({bootSelError, bootMode}, expMode(pm, w, s));
		chk(bootModeValid, !pm);
		chk(blockZeroMap, !pm);
		chk(globalIntMask, 1'b1);
		if (!pm && w && s[1:0] != 2'b00)
			chk({eepromSourceField, warmEntryField}, {2{s[7:2]}});
	endtask
	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge clk);
		ioRd <= 1'b1;
		ioAddr <= a;
		@(posedge clk);
		ioRd <= 1'b0;
		#1;
		chk(ioRdAck, 1'b1);
		chk(ioRdData, e);
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge clk);
		ioWr <= 1'b1;
		ioAddr <= 16'hffe4;
		ioWrData <= d;
		@(posedge clk);
		ioWr <= 1'b0;
	endtask
	task automatic vec(input int n);
		@(posedge clk);
		intReq <= 1'b1;
		intNum <= 5'(n);
		@(posedge clk);
		intReq <= 1'b0;
		#1;
		chk(vecFetchAddr, 16'(n * 2));
		@(posedge clk);
		#1;
		chk(vecFetchAddr, expVec(n));
		@(posedge clk);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		r = 16'($urandom(32'h08c2));
		boot(1'b1, 1'b1, 16'h0000);
		boot(1'b0, 1'b0, 16'h0000);
		foreach (lo[i])
		begin
			r = 16'($urandom);
			boot(1'b0, 1'b1, {r[15:8], (lo[i][1:0] != 2'b00) ? r[7:2] : lo[i][7:2], lo[i][1:0]});
		end
		rd(16'hffe4, 16'h000e);
		wr(16'h7ff0);
		rd(16'hffe4, 16'h0008);
		wr(16'h8003);
		rd(16'hffe4, 16'h800b);
		chk(readStrobeSelect, 1'b1);
		wr(16'h0002);
		rd(16'h1234, 16'h0000);
		@(posedge clk);
		memIsProg <= 1'b1;
		memAddr <= 16'h8000;
		@(posedge clk);
		memIsProg <= 1'b0;
		memAddr <= 16'h0800;
		#1;
		chk(sramSelect, 1'b1);
		@(posedge clk);
		bootDone <= 1'b1;
		#1;
		chk(sramSelect, 1'b0);
		@(posedge clk);
		bootDone <= 1'b0;
		repeat (2) @(posedge clk);
		intMaskClear <= 1'b1;
		@(posedge clk);
		intMaskClear <= 1'b0;
		@(posedge clk);
		#1;
		chk(globalIntMask, 1'b0);
		for (int n = 1; n < 32; n++)
			if (n != 19)
				vec(n);
		complete_run;
	end
	// Watchdog, well beyond the roughly 470 cycles the tests need
	initial
	begin
		#200000;
		fails++;
		complete_run;
	end
endmodule
